// File: bench/tbmf_asserts.sv
/*
 * Port checker of the two-wire bus master, bound to tbmf_top.
 * Assumes one clock domain and the register map of tbmf_map.svh.
 */
`include "tbmf_map.svh"

module tbmf_asserts (
    input wire logic                    clk,
    input wire logic                    reset_n,
    input wire tbmf_pkg::tbmf_sfr_req_t sfrReq,
    input wire logic                    rxIrqOnFull,
    input wire logic                    serialPinOwnerSelect,
    input wire logic                    sdaIn,
    input wire logic [7:0]              sfrRdData,
    input wire tbmf_pkg::tbmf_pins_t    pins
);
    timeunit 1ns;
    timeprecision 1ps;
    import tbmf_pkg::*;

    logic [7:0] modeQ;
    logic [7:0] targetQ;
    logic [7:0] runQ;
    logic       oeQ;
    logic [7:0] halfBit;
    logic       enQ;

    // Shadow copies let readback and clock timing be judged without the body.
    assign halfBit = 8'h08 << modeQ[6:5];
    assign enQ     = modeQ[`TBMF_MODE_EN];
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            modeQ   <= 8'h00;
            targetQ <= 8'h00;
            runQ    <= 8'h00;
            oeQ     <= 1'b0;
        end else begin
            if (sfrReq.wr && sfrReq.addr == `TBMF_ADR_MODE) begin
                modeQ <= sfrReq.wdata;
            end
            if (sfrReq.wr && sfrReq.addr == `TBMF_ADR_TARGET) begin
                targetQ <= sfrReq.wdata;
            end
            oeQ  <= pins.sclOe;
            runQ <= (pins.sclOe != oeQ) ? 8'h01 : runQ + {7'h00, runQ != 8'hFF};
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    AST_OWNER_RELEASES: assert property (
        $past(serialPinOwnerSelect) && serialPinOwnerSelect |-> !pins.sclOe && !pins.sdaOe)
        else $error("pins pulled while not owned");
    AST_OPEN_DRAIN: assert property (!pins.sclOut && !pins.sdaOut)
        else $error("pin driven high");
    AST_DISABLED_QUIET: assert property ((!enQ)[*3] |-> !pins.sclOe && !pins.sdaOe)
        else $error("bus active while disabled");
    AST_SCL_LOW_TIME: assert property (oeQ && !pins.sclOe |-> runQ == halfBit)
        else $error("clock low phase length wrong");
    AST_SCL_HIGH_TIME: assert property (!oeQ && pins.sclOe |-> runQ >= halfBit)
        else $error("clock high phase too short");
    AST_TARGET_READBACK: assert property (
        sfrReq.rd && !sfrReq.wr && sfrReq.addr == `TBMF_ADR_TARGET |=> sfrRdData == targetQ)
        else $error("target register readback wrong");
    AST_TXBUF_WRITE_ONLY: assert property (
        sfrReq.rd && sfrReq.addr == `TBMF_ADR_TXBUF |=> sfrRdData == 8'h00)
        else $error("transmit buffer readable");
    AST_SDA_SCL_APART: assert property (
        enQ && $past(enQ) && !serialPinOwnerSelect && $changed(pins.sdaOe) |-> !$changed(pins.sclOe))
        else $error("data and clock moved together");

    COV_SLOW_CLOCK: cover property (pins.sclOe && modeQ[6:5] == 2'h3);
    COV_BOTH_STROBES: cover property (sfrReq.wr && sfrReq.rd);
    COV_TARGET_READ: cover property (sfrReq.rd && sfrReq.addr == `TBMF_ADR_TARGET);
endmodule

bind tbmf_top tbmf_asserts i_asserts (.clk(clk), .reset_n(reset_n), .sfrReq(sfrReq), .rxIrqOnFull(rxIrqOnFull),
    .serialPinOwnerSelect(serialPinOwnerSelect), .sdaIn(sdaIn), .sfrRdData(sfrRdData), .pins(pins));

// File: bench/tbmf_slave.sv
/*
 * Behavioural target device on the two-wire bus.
 * Assumes resolved wire levels with pull-ups and no clock stretching.
 */
module tbmf_slave #(
    parameter logic [6:0] SLAVE_ADDR = 7'h2C
) (
    input  wire logic       scl,
    input  wire logic       sda,
    output      logic       sdaPull,
    output      logic       gotByte,
    output      logic [7:0] gotData,
    output      int         starts,
    output      int         stops
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] sh = 8'h00;
    logic [7:0] outB = 8'h00;
    logic [7:0] rdByte = 8'hA0;
    logic       live = 1'b0;
    logic       inAddr = 1'b0;
    logic       reading = 1'b0;
    int         bitN = 0;

    initial begin
        sdaPull = 1'b0;
        gotByte = 1'b0;
        gotData = 8'h00;
        starts  = 0;
        stops   = 0;
    end

    // The first clock fall after a START opens bit zero, hence minus one.
    always @(negedge sda) if (scl) begin
        starts++;
        live    = 1'b1;
        inAddr  = 1'b1;
        reading = 1'b0;
        bitN    = -1;
        sdaPull = 1'b0;
    end
    always @(posedge sda) if (scl) begin
        stops++;
        live = 1'b0;
    end
    always @(posedge scl) if (live) begin
        gotByte = 1'b0;
        if (bitN < 8) sh = {sh[6:0], sda};
        else if (reading && sda) live = 1'b0;
    end
    always @(negedge scl) if (live) begin
        bitN = (bitN == 8) ? 0 : bitN + 1;
        if (bitN == 8 && inAddr) begin
            inAddr  = 1'b0;
            reading = sh[0];
            live    = (sh[7:1] == SLAVE_ADDR);
            sdaPull = live;
        end else if (bitN == 8) begin
            gotData = sh;
            gotByte = !reading;
            sdaPull = !reading;
        end else begin
            if (bitN == 0 && reading) begin
                outB   = rdByte;
                rdByte = rdByte + 8'h01;
            end
            sdaPull = reading && !outB[7 - bitN];
        end
    end
endmodule

// File: bench/tbmf_tb_top.sv
/*
 * Self-checking bench of the two-wire bus master with a target model.
 * Assumes design, checker and target model are compiled before it.
 */
`include "tbmf_map.svh"

module tbmf_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import tbmf_pkg::*;

    localparam logic [6:0] TGT = 7'h2C;
    localparam logic [7:0] REGS [6] = '{8'hE8, 8'hE9, 8'hEA, 8'h9A, 8'h9B, 8'h55};
    localparam logic [4:0] RCNT [3] = '{5'h03, 5'h01, 5'h02};
    localparam logic       FULLQ [3] = '{1'b1, 1'b1, 1'b0};
    localparam logic [7:0] RFLG [3] = '{8'h2C, 8'h08, 8'h28};

    logic          clk = 1'b0;
    logic          reset_n = 1'b0;
    tbmf_sfr_req_t req = '0;
    logic          onFull = 1'b0;
    logic          owner = 1'b0;
    logic [7:0]    rdData;
    tbmf_pins_t    pins;
    logic          sdaPull;
    logic          gotByte;
    logic          rdPend = 1'b0;
    logic [7:0]    gotData;
    logic [7:0]    nextRx = 8'hA0;
    logic [15:0]   note;
    logic [15:0]   rdQ [$];
    logic [7:0]    txQ [$];
    int            starts, stops, c, s0, p0;
    int            err_count = 0;
    int            samples_checked = 0;
    int            seed = 10;
    wire           scl = !pins.sclOe;
    wire           sda = !(pins.sdaOe || sdaPull);

    always #2.5 clk = !clk;

    tbmf_top i_dut (.clk(clk), .reset_n(reset_n), .sfrReq(req), .rxIrqOnFull(onFull),
        .serialPinOwnerSelect(owner), .sdaIn(sda), .sfrRdData(rdData), .pins(pins));
    tbmf_slave #(.SLAVE_ADDR(TGT)) i_slave (.scl(scl), .sda(sda), .sdaPull(sdaPull), .gotByte(gotByte),
        .gotData(gotData), .starts(starts), .stops(stops));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        if (err_count == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic sfr(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        req = '{wr: w, rd: r, addr: a, wdata: d};
        @(negedge clk);
        req.wr = 1'b0;
        req.rd = 1'b0;
    endtask

    // A zero mask makes a poll that only keeps the note queue in step.
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] mask);
        rdQ.push_back({mask, exp & mask});
        sfr(1'b0, 1'b1, a, 8'h00);
    endtask

    task automatic push(input logic keep);
        logic [7:0] d;
        d = 8'($random(seed));
        if (keep) txQ.push_back(d);
        sfr(1'b1, 1'b0, `TBMF_ADR_TXBUF, d);
    endtask

    task automatic waitIdle();
        int n;
        n = 0;
        repeat (2) @(negedge clk);
        do begin
            rd(`TBMF_ADR_FLAGS, 8'h00, 8'h00);
            n++;
        end while (rdData[`TBMF_F_BUSY] !== 1'b0 && n < 20000);
        if (n >= 20000) begin
            err_count++;
            close_out();
        end
    endtask

    task automatic sclRise(output int cnt);
        logic p;
        cnt = 0;
        p = scl;
        do begin
            @(negedge clk);
            cnt++;
            if (scl && !p) break;
            p = scl;
        end while (cnt < 5000);
        if (cnt >= 5000) begin
            err_count++;
            close_out();
        end
    endtask

    always @(posedge clk) rdPend <= req.rd;
    always @(negedge clk) if (rdPend) begin
        note = rdQ.pop_front();
        check(rdData & note[15:8], note[7:0]);
    end
    always @(posedge gotByte) check(gotData, txQ.pop_front());

    initial begin
        repeat (20) @(negedge clk);
        reset_n = 1'b1;
        owner = 1'b1;
        foreach (REGS[i]) rd(REGS[i], 8'h00, 8'hFF);
        sfr(1'b1, 1'b0, `TBMF_ADR_TARGET, {TGT, 1'b0});
        rd(`TBMF_ADR_TARGET, {TGT, 1'b0}, 8'hFF);
        rd(`TBMF_ADR_FLAGS, 8'h00, 8'hFF);
        owner = 1'b0;
        for (int dv = 0; dv < 4; dv++) begin
            sfr(1'b1, 1'b0, `TBMF_ADR_MODE, {1'b1, dv[1:0], 5'h00});
            for (int k = 0; k < (dv == 0 ? 4 : 1); k++) push(1'b1);
            if (dv == 0) begin
                sfr(1'b1, 1'b0, `TBMF_ADR_TXBUF, 8'h5A);
                rd(`TBMF_ADR_FLAGS, 8'h0D, 8'hFF);
                sfr(1'b1, 1'b0, `TBMF_ADR_FLAGS, 8'h00);
            end
            sfr(1'b1, 1'b0, `TBMF_ADR_TARGET, {TGT, 1'b0});
            sclRise(c);
            sclRise(c);
            check(c[7:0], 8'h10 << dv);
            waitIdle();
            rd(`TBMF_ADR_FLAGS, 8'h10, 8'hFF);
        end
        check(8'(txQ.size()), 8'h00);
        sfr(1'b1, 1'b0, `TBMF_ADR_MODE, 8'h80);
        push(1'b0);
        push(1'b0);
        sfr(1'b1, 1'b0, `TBMF_ADR_FLAGS, 8'h80);
        rd(`TBMF_ADR_FLAGS, 8'h00, 8'h0C);
        s0 = starts;
        p0 = stops;
        push(1'b1);
        sfr(1'b1, 1'b0, `TBMF_ADR_TARGET, {TGT, 1'b0});
        repeat (40) @(negedge clk);
        push(1'b1);
        sfr(1'b1, 1'b0, `TBMF_ADR_TARGET, {TGT, 1'b0});
        waitIdle();
        check(8'(starts - s0), 8'h02);
        check(8'(stops - p0), 8'h01);
        push(1'b0);
        sfr(1'b1, 1'b0, `TBMF_ADR_TARGET, {TGT ^ 7'h01, 1'b0});
        waitIdle();
        rd(`TBMF_ADR_FLAGS, 8'h40, 8'hEF);
        sfr(1'b1, 1'b0, `TBMF_ADR_FLAGS, 8'h00);
        rd(`TBMF_ADR_FLAGS, 8'h00, 8'hFF);
        rdQ.push_back(16'h0000);
        sfr(1'b1, 1'b1, 8'h55, 8'h00);
        rd(`TBMF_ADR_FLAGS, 8'h02, 8'hFF);
        sfr(1'b1, 1'b0, `TBMF_ADR_FLAGS, 8'h00);
        for (int t = 0; t < 3; t++) begin
            sfr(1'b1, 1'b0, `TBMF_ADR_MODE, {3'h4, RCNT[t]});
            onFull = FULLQ[t];
            sfr(1'b1, 1'b0, `TBMF_ADR_TARGET, {TGT, 1'b1});
            waitIdle();
            rd(`TBMF_ADR_FLAGS, RFLG[t], 8'hFF);
            for (int k = 0; k <= RCNT[t]; k++) begin
                rd(`TBMF_ADR_RXBUF, nextRx, 8'hFF);
                nextRx++;
            end
            rd(`TBMF_ADR_RXBUF, 8'h00, 8'hFF);
            sfr(1'b1, 1'b0, `TBMF_ADR_FLAGS, 8'h00);
            rd(`TBMF_ADR_FLAGS, 8'h00, 8'hFF);
        end
        close_out();
    end
endmodule

// File: design/tbmf_fifo.sv
/*
 * Four-entry byte FIFO with flush, used for both transmit and receive.
 * Assumes the owner never pushes when full nor pops when empty.
 */
`include "tbmf_map.svh"

module tbmf_fifo (
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic       push,
    input  wire logic [7:0] pushData,
    input  wire logic       pop,
    input  wire logic       flush,
    output      logic [7:0] popData,
    output      logic [2:0] count,
    output      logic       full,
    output      logic       empty
);
    import tbmf_pkg::*;

    tbmf_fifo_t f_q;
    tbmf_fifo_t f_d;

    assign popData = f_q.mem[f_q.rp];
    assign count   = f_q.cnt;
    assign full    = (f_q.cnt == `TBMF_FIFO_DEPTH);
    assign empty   = (f_q.cnt == `TBMF_FIFO_EMPTY);

    always_comb begin
        f_d = f_q;
        if (flush) begin
            f_d.wp  = f_q.rp;
            f_d.cnt = `TBMF_FIFO_EMPTY;
        end else begin
            if (push) begin
                f_d.mem[f_q.wp] = pushData;
                f_d.wp          = f_q.wp + 2'h1;
            end
            if (pop) begin
                f_d.rp = f_q.rp + 2'h1;
            end
            f_d.cnt = f_q.cnt + {2'h0, push} - {2'h0, pop};
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            f_q <= '0;
        end else begin
            f_q <= f_d;
        end
    end
endmodule

// File: design/tbmf_map.svh
/*
 * Register addresses, field positions, reset values and timing counts of the
 * two-wire bus master with transmit and receive FIFOs.
 * Assumes inclusion by its bare name from the design modules and the bench.
 */
// How it works
// - SCL is core clock over 16/32/64/128.
// - Reads stop after count plus one bytes.
// - Address write holds target, starts transaction.
// - Address bit 0 selects read or write.
// - Busy flag; software setting it flushes transmit.
// - Missing acknowledge flag stops transfer, write-zero clears.
// - Receive flag set while receive FIFO holds data.
// - Transmit flag set when transmit FIFO empties.
// - Level code of active FIFO: 00/10/11.
// - Simultaneous write and read sets access error.
// - Writing full transmit FIFO sets overfill error.
// - Automatic acknowledge per byte, NACK on last.
// - Address rewrite mid-transfer gives repeated START.
// - Four-byte receive and transmit FIFOs, preloadable.
// - Empty transmit FIFO at byte load stops.
// - Write error flushes the transmit FIFO.
// - Receive flag per byte or on full.
// - Master works only while mode bit 7 set.
// - Pin owner select hands pins to SPI.
`ifndef TBMF_MAP_SVH
`define TBMF_MAP_SVH

`define TBMF_ADR_MODE    8'hE8
`define TBMF_ADR_TARGET  8'hE9
`define TBMF_ADR_FLAGS   8'hEA
`define TBMF_ADR_TXBUF   8'h9A
`define TBMF_ADR_RXBUF   8'h9B

`define TBMF_MODE_EN     7
`define TBMF_DIV_HI      6
`define TBMF_DIV_LO      5
`define TBMF_RCT_HI      4
`define TBMF_RCT_LO      0
`define TBMF_DIR_BIT     0

`define TBMF_F_BUSY      7
`define TBMF_F_NOACK     6
`define TBMF_F_RXP       5
`define TBMF_F_TXE       4
`define TBMF_F_ACC       1
`define TBMF_F_TXWR      0

`define TBMF_RST_BYTE    8'h00
`define TBMF_LVL_EMPTY   2'h0
`define TBMF_LVL_HALF    2'h2
`define TBMF_LVL_FULL    2'h3
`define TBMF_FIFO_DEPTH  3'h4
`define TBMF_FIFO_EMPTY  3'h0

`define TBMF_QTR_BASE    6'h04
`define TBMF_QTR_ONE     6'h01
`define TBMF_PH_FIRST    2'h0
`define TBMF_PH_SDA      2'h1
`define TBMF_PH_UP       2'h2
`define TBMF_PH_LAST     2'h3
`define TBMF_BIT_LASTD   4'h7
`define TBMF_BIT_ACK     4'h8
`define TBMF_BIT_ONE     4'h1
`define TBMF_CNT_ONE     5'h01

`endif

// File: design/tbmf_pkg.sv
/*
 * Types shared by the two-wire bus master and its FIFO.
 * Assumes tbmf_map.svh is on the include path.
 */
package tbmf_pkg;

    typedef enum logic [5:0] {
        ST_IDLE  = 6'h01,
        ST_START = 6'h02,
        ST_ADDR  = 6'h04,
        ST_TX    = 6'h08,
        ST_RX    = 6'h10,
        ST_STOP  = 6'h20
    } tbmf_state_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } tbmf_sfr_req_t;

    typedef struct packed {
        logic sclOut;
        logic sclOe;
        logic sdaOut;
        logic sdaOe;
    } tbmf_pins_t;

    typedef struct packed {
        logic mode;
        logic target;
        logic flags;
        logic txBuf;
        logic rxBuf;
    } tbmf_sel_t;

    typedef struct packed {
        logic [3:0][7:0] mem;
        logic [1:0]      wp;
        logic [1:0]      rp;
        logic [2:0]      cnt;
    } tbmf_fifo_t;

    typedef struct packed {
        logic [7:0]  mode;
        logic [7:0]  target;
        logic [7:0]  rdata;
        logic        busy;
        logic        noack;
        logic        rxp;
        logic        txe;
        logic        acc;
        logic        txwr;
        logic        txWasFilled;
        logic        pend;
        logic        rep;
        logic        curDir;
        tbmf_state_t state;
        logic [1:0]  phase;
        logic [5:0]  qtr;
        logic [3:0]  bitIdx;
        logic [7:0]  shift;
        logic [4:0]  rxCnt;
        logic        sclLow;
        logic        sdaLow;
        logic [2:0]  sync;
        logic        sdaLvl;
        tbmf_pins_t  pins;
    } tbmf_top_t;

endpackage

// File: design/tbmf_top.sv
/*
 * Two-wire bus master: special function register port, bit engine driving
 * open-drain SCL and SDA, and a transmit and a receive FIFO.
 * Assumes the core writes and reads registers with one-cycle strobes and
 * that the wire levels are resolved outside from the output enables.
 * SCL is never read back, so clock stretching and arbitration are not
 * supported; a slow target must keep pace with the divided clock.
 */
`include "tbmf_map.svh"

module tbmf_top (
    input  wire logic                    clk,
    input  wire logic                    reset_n,
    input  wire tbmf_pkg::tbmf_sfr_req_t sfrReq,
    input  wire logic                    rxIrqOnFull,
    input  wire logic                    serialPinOwnerSelect,
    input  wire logic                    sdaIn,
    output      logic [7:0]              sfrRdData,
    output      tbmf_pkg::tbmf_pins_t    pins
);
    import tbmf_pkg::*;

    tbmf_top_t  s_q;
    tbmf_top_t  s_d;

    tbmf_sel_t  wrSel;
    tbmf_sel_t  rdSel;

    logic       txPush;
    logic       txPop;
    logic       txFlush;
    logic       txFull;
    logic       txEmpty;
    logic [2:0] txCount;
    logic [7:0] txHead;

    logic       rxPush;
    logic       rxPop;
    logic       rxFull;
    logic       rxEmpty;
    logic [2:0] rxCount;
    logic [7:0] rxHead;
    logic [7:0] rxData;

    logic [5:0] qtrLimit;
    logic       tick;
    logic       bitEnd;
    logic       lastByte;
    logic       finish;
    logic       enabled;
    logic       noackSet;
    logic       rxSet;
    logic       txSet;
    logic [2:0] lvlCount;
    logic [1:0] lvlCode;
    logic [7:0] clrMask;
    logic       rxRoom;
    logic [7:0] flagsByte;

    function automatic tbmf_sel_t decode(input logic [7:0] a);
        tbmf_sel_t d;
        d        = '0;

        d.mode   = (a == `TBMF_ADR_MODE);
        d.target = (a == `TBMF_ADR_TARGET);
        d.flags  = (a == `TBMF_ADR_FLAGS);
        d.txBuf  = (a == `TBMF_ADR_TXBUF);
        d.rxBuf  = (a == `TBMF_ADR_RXBUF);
        return d;
    endfunction

    tbmf_fifo u_txFifo (
        .clk      (clk),
        .reset_n  (reset_n),
        .push     (txPush),
        .pushData (sfrReq.wdata),
        .pop      (txPop),
        .flush    (txFlush),
        .popData  (txHead),
        .count    (txCount),
        .full     (txFull),
        .empty    (txEmpty)
    );

    // Receive data is pushed only while there is room: software must drain in time.
    tbmf_fifo u_rxFifo (
        .clk      (clk),
        .reset_n  (reset_n),
        .push     (rxPush),
        .pushData (rxData),
        .pop      (rxPop),
        .flush    (1'b0),
        .popData  (rxHead),
        .count    (rxCount),
        .full     (rxFull),
        .empty    (rxEmpty)
    );

    assign sfrRdData = s_q.rdata;
    assign pins      = s_q.pins;

    // Each bit takes four quarters; the quarter length scales the SCL rate.
    assign qtrLimit = (`TBMF_QTR_BASE << s_q.mode[`TBMF_DIV_HI:`TBMF_DIV_LO]) - `TBMF_QTR_ONE;
    assign tick     = (s_q.qtr == qtrLimit);
    assign bitEnd   = tick && (s_q.phase == `TBMF_PH_LAST);

    assign lastByte = (s_q.rxCnt == s_q.mode[`TBMF_RCT_HI:`TBMF_RCT_LO]);
    assign enabled  = s_q.mode[`TBMF_MODE_EN];

    assign rxData   = {s_q.shift[6:0], s_q.sdaLvl};
    assign lvlCount = s_q.target[`TBMF_DIR_BIT] ? rxCount : txCount;

    // A byte that arrives while the receive FIFO is full is lost.
    assign rxRoom   = !rxFull;

    assign flagsByte = {s_q.busy,
                        s_q.noack,
                        s_q.rxp,
                        s_q.txe,
                        lvlCode,
                        s_q.acc,
                        s_q.txwr};

    // Level code 01 is reserved and never produced.
    always_comb begin
        if (lvlCount == `TBMF_FIFO_EMPTY) begin
            lvlCode = `TBMF_LVL_EMPTY;
        end else if (lvlCount == `TBMF_FIFO_DEPTH) begin
            lvlCode = `TBMF_LVL_FULL;
        end else begin
            lvlCode = `TBMF_LVL_HALF;
        end
    end

    always_comb begin
        s_d      = s_q;

        wrSel    = sfrReq.wr ? decode(sfrReq.addr) : '0;
        rdSel    = sfrReq.rd ? decode(sfrReq.addr) : '0;

        txPush   = 1'b0;
        txPop    = 1'b0;
        txFlush  = 1'b0;
        rxPush   = 1'b0;
        rxPop    = 1'b0;
        finish   = 1'b0;
        noackSet = 1'b0;

        // Only the second and third stages are compared, filtering glitches.
        s_d.sync = {s_q.sync[1:0], sdaIn};
        if (s_q.sync[1] == s_q.sync[2]) begin
            s_d.sdaLvl = s_q.sync[2];
        end

        if (s_q.state == ST_IDLE || tick) begin
            s_d.qtr = '0;
        end else begin
            s_d.qtr = s_q.qtr + `TBMF_QTR_ONE;
        end
        if (tick) begin
            s_d.phase = s_q.phase + 2'h1;
        end

        unique case (s_q.state)
            ST_IDLE: begin
                s_d.sclLow = 1'b0;
                s_d.sdaLow = 1'b0;

                if (s_q.pend) begin
                    s_d.state = ST_START;
                    s_d.rep   = 1'b0;
                    s_d.pend  = 1'b0;
                    s_d.phase = `TBMF_PH_FIRST;
                end
            end

            ST_START: begin
                // SCL is pulled low first on a repeated start, so raising SDA is no STOP.
                s_d.sclLow = (s_q.phase < `TBMF_PH_UP) && s_q.rep;
                if (s_q.phase == `TBMF_PH_LAST) begin
                    s_d.sdaLow = 1'b1;
                end else if (s_q.phase != `TBMF_PH_FIRST) begin
                    s_d.sdaLow = 1'b0;
                end

                if (bitEnd) begin
                    s_d.shift  = s_q.target;
                    s_d.curDir = s_q.target[`TBMF_DIR_BIT];
                    s_d.bitIdx = '0;
                    s_d.rxCnt  = '0;
                    s_d.state  = ST_ADDR;
                end
            end

            // Address and data bytes share this path; bit 8 is the acknowledge.
            ST_ADDR, ST_TX: begin
                s_d.sclLow = (s_q.phase < `TBMF_PH_UP);
                if (s_q.phase == `TBMF_PH_SDA) begin
                    s_d.sdaLow = (s_q.bitIdx != `TBMF_BIT_ACK) && !s_q.shift[7];
                end

                if (bitEnd) begin
                    if (s_q.bitIdx != `TBMF_BIT_ACK) begin
                        s_d.shift  = {s_q.shift[6:0], 1'b0};
                        s_d.bitIdx = s_q.bitIdx + `TBMF_BIT_ONE;
                    end else if (s_q.sdaLvl) begin
                        noackSet = 1'b1;
                        txFlush  = !s_q.curDir;
                        finish   = 1'b1;
                    end else if (s_q.curDir) begin
                        s_d.bitIdx = '0;
                        s_d.state  = ST_RX;
                    end else if (txEmpty) begin
                        finish = 1'b1;
                    end else begin
                        txPop      = 1'b1;
                        s_d.shift  = txHead;
                        s_d.bitIdx = '0;
                        s_d.state  = ST_TX;
                    end
                end
            end

            // The last byte gets a NACK so the target lets go of SDA.
            ST_RX: begin
                s_d.sclLow = (s_q.phase < `TBMF_PH_UP);
                if (s_q.phase == `TBMF_PH_SDA) begin
                    s_d.sdaLow = (s_q.bitIdx == `TBMF_BIT_ACK) && !lastByte;
                end

                if (bitEnd) begin
                    if (s_q.bitIdx != `TBMF_BIT_ACK) begin
                        s_d.shift  = rxData;
                        s_d.bitIdx = s_q.bitIdx + `TBMF_BIT_ONE;
                        rxPush     = (s_q.bitIdx == `TBMF_BIT_LASTD) && rxRoom;
                    end else if (lastByte) begin
                        finish = 1'b1;
                    end else begin
                        s_d.bitIdx = '0;
                        s_d.rxCnt  = s_q.rxCnt + `TBMF_CNT_ONE;
                    end
                end
            end

            // SDA rises while SCL is high, which marks the STOP.
            ST_STOP: begin
                s_d.sclLow = (s_q.phase < `TBMF_PH_UP);
                if (s_q.phase == `TBMF_PH_SDA) begin
                    s_d.sdaLow = 1'b1;
                end else if (s_q.phase == `TBMF_PH_LAST) begin
                    s_d.sdaLow = 1'b0;
                end

                if (bitEnd) begin
                    s_d.state = ST_IDLE;
                    s_d.busy  = s_q.pend;
                end
            end
        endcase

        // A pending address write turns the STOP into a repeated START.
        if (finish) begin
            if (s_q.pend) begin
                s_d.state = ST_START;
                s_d.rep   = 1'b1;
                s_d.pend  = 1'b0;
            end else begin
                s_d.state = ST_STOP;
            end
        end

        // Dropping the enable abandons a transfer at once, without a STOP.
        if (!enabled) begin
            s_d.state  = ST_IDLE;
            s_d.pend   = 1'b0;
            s_d.busy   = 1'b0;
            s_d.sclLow = 1'b0;
            s_d.sdaLow = 1'b0;
        end

        // Register writes come after the engine so software has the last word.
        if (wrSel.mode) begin
            s_d.mode = sfrReq.wdata;
        end

        if (wrSel.target) begin
            s_d.target = sfrReq.wdata;
            if (enabled) begin
                s_d.pend = 1'b1;
                s_d.busy = 1'b1;
            end
        end

        if (wrSel.flags && sfrReq.wdata[`TBMF_F_BUSY]) begin
            txFlush = 1'b1;
        end

        if (wrSel.txBuf && !txFull) begin
            txPush = 1'b1;
        end
        rxPop = rdSel.rxBuf && !rxEmpty;

        // Read data is registered and stands until the next read.
        if (sfrReq.rd) begin
            if (rdSel.mode) begin
                s_d.rdata = s_q.mode;
            end else if (rdSel.target) begin
                s_d.rdata = s_q.target;
            end else if (rdSel.flags) begin
                s_d.rdata = flagsByte;
            end else if (rdSel.rxBuf) begin
                s_d.rdata = rxEmpty ? `TBMF_RST_BYTE : rxHead;
            end else begin
                s_d.rdata = `TBMF_RST_BYTE;
            end
        end

        // A hardware set in the same cycle as a write of zero wins.
        clrMask = wrSel.flags ? ~sfrReq.wdata : `TBMF_RST_BYTE;
        rxSet   = rxIrqOnFull ? rxFull : !rxEmpty;
        txSet   = txEmpty && s_q.txWasFilled;

        s_d.txWasFilled = !txEmpty;
        s_d.noack = noackSet || (s_q.noack && !clrMask[`TBMF_F_NOACK]);
        s_d.rxp   = rxSet || (s_q.rxp && !clrMask[`TBMF_F_RXP]);
        s_d.txe   = txSet || (s_q.txe && !clrMask[`TBMF_F_TXE]);
        s_d.acc   = (sfrReq.wr && sfrReq.rd) || (s_q.acc && !clrMask[`TBMF_F_ACC]);
        s_d.txwr  = (wrSel.txBuf && txFull) || (s_q.txwr && !clrMask[`TBMF_F_TXWR]);

        // Open drain: outputs stay low, enables pull; SPI ownership releases both.
        s_d.pins.sclOut = 1'b0;
        s_d.pins.sdaOut = 1'b0;
        s_d.pins.sclOe  = s_d.sclLow && !serialPinOwnerSelect;
        s_d.pins.sdaOe  = s_d.sdaLow && !serialPinOwnerSelect;
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            s_q       <= '0;
            s_q.state <= ST_IDLE;
        end else begin
            s_q <= s_d;
        end
    end
endmodule
